// ### src/mstr_pkg.sv
package mstr_pkg;

  // ***************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ***************************************************************
  localparam logic [3:0] OFS_CTRL0  = 4'h0;
  localparam logic [3:0] OFS_CTRL1  = 4'h4;
  localparam logic [3:0] OFS_CTRL2  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // field positions
  localparam int RES_LSB   = 0;   // ctrl0 [2:0] step_resolution
  localparam int PEAK_LSB  = 8;   // ctrl0 [12:8] peak_amplitude_code
  localparam int ROT_BIT   = 0;   // ctrl1 rotation_sense_bit
  localparam int EDGE_BIT  = 1;   // ctrl1 step_edge_select
  localparam int TRANS_BIT = 0;   // ctrl2 backemf_transparent_bit
  localparam int GAIN_BIT  = 1;   // ctrl2 backemf_gain_bit
  localparam int LOWP_BIT  = 2;   // ctrl2 low_power_bit
  localparam int ACTR_LSB  = 8;   // status [10:8] active resolution
  localparam int RANGE_LSB = 12;  // status [13:12] current range

  // reset values
  localparam logic [2:0] RST_RES   = 3'h0;
  localparam logic [4:0] RST_PEAK  = 5'h00;
  localparam logic [6:0] RST_INDEX = 7'h00;

  // step resolution codes
  localparam logic [2:0] RES_32 = 3'h0;
  localparam logic [2:0] RES_16 = 3'h1;
  localparam logic [2:0] RES_8  = 3'h2;
  localparam logic [2:0] RES_4  = 3'h3;
  localparam logic [2:0] RES_2  = 3'h4;

  // peak code range boundaries
  localparam logic [4:0] RANGE1_MIN = 5'h09;
  localparam logic [4:0] RANGE2_MIN = 5'h10;
  localparam logic [4:0] RANGE3_MIN = 5'h17;

  // first quadrant of the circular profile, tenths of a percent
  localparam logic [9:0] QUAD_LUT [33] = '{
    10'h000, 10'h023, 10'h051, 10'h07F, 10'h0AE, 10'h0DD, 10'h10B,
    10'h13A, 10'h15D, 10'h17F, 10'h1AE, 10'h1D1, 10'h1F4, 10'h222,
    10'h245, 10'h268, 10'h28B, 10'h2AE, 10'h2D1, 10'h2F3, 10'h316,
    10'h33A, 10'h351, 10'h368, 10'h37F, 10'h396, 10'h3A2, 10'h3AD,
    10'h3B9, 10'h3C5, 10'h3D1, 10'h3DC, 10'h3E8};

  // peak coil current per amplitude code, mA
  localparam logic [9:0] PEAK_MA [32] = '{
    10'h00F, 10'h01E, 10'h02D, 10'h032, 10'h037, 10'h03D, 10'h043,
    10'h04A, 10'h052, 10'h05B, 10'h064, 10'h06E, 10'h07A, 10'h087,
    10'h095, 10'h0A4, 10'h0B5, 10'h0C8, 10'h0DD, 10'h0F4, 10'h10D,
    10'h129, 10'h148, 10'h16A, 10'h190, 10'h1B9, 10'h1E7, 10'h21A,
    10'h252, 10'h290, 10'h2D4, 10'h320};

endpackage : mstr_pkg

// ### src/mstr_translator.sv
`timescale 1ns/1ps

module mstr_translator #(
  parameter int VW = 10
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // motion pins
  input  wire logic                 step_pulse_input,
  input  wire logic                 rotation_sense_pin,
  // pwm regulator side
  input  wire logic                 pwm_period_start,
  input  wire logic                 pwm_sample_strobe,
  input  wire logic                 coil_zero_x,
  input  wire logic                 coil_zero_y,
  input  wire logic [VW-1:0]        coil_voltage,
  output logic signed [10:0]        coil_x_ref,
  output logic signed [10:0]        coil_y_ref,
  output logic      [9:0]           peak_current_ma,
  output logic      [1:0]           current_range,
  output logic      [VW-1:0]        backemf_output_pin,
  output logic      [6:0]           microstep_index
);

  // ***************************************************************
  // helpers
  // ***************************************************************

  // index increment per resolution code; unused codes act as half step
  function automatic logic [6:0] step_size(input logic [2:0] code);
    unique case (code)
      mstr_pkg::RES_32: step_size = 7'h01;
      mstr_pkg::RES_16: step_size = 7'h02;
      mstr_pkg::RES_8:  step_size = 7'h04;
      mstr_pkg::RES_4:  step_size = 7'h08;
      default:          step_size = 7'h10;
    endcase
  endfunction : step_size

  // signed coil value from the quadrant table
  function automatic logic signed [10:0] coil_val(input logic [6:0] idx,
                                                  input logic       is_y);
    logic [5:0] k;
    logic [5:0] kk;
    logic       neg;
    k  = {1'b0, idx[4:0]};
    kk = 6'(6'h20 - k);
    // x: q0 +s(k), q1 +s(32-k), q2 -s(k), q3 -s(32-k); y is a quarter on
    if (is_y) begin
      neg      = idx[6] ^ idx[5];
      coil_val = 11'(signed'({1'b0, mstr_pkg::QUAD_LUT[idx[5] ? k : kk]}));
    end else begin
      neg      = idx[6];
      coil_val = 11'(signed'({1'b0, mstr_pkg::QUAD_LUT[idx[5] ? kk : k]}));
    end
    if (neg) begin
      coil_val = -coil_val;
    end
  endfunction : coil_val

  // ***************************************************************
  // register state
  // ***************************************************************
  logic [2:0]    step_resolution_q;
  logic [4:0]    peak_amplitude_code_q;
  logic          rotation_sense_bit_q;
  logic          step_edge_select_q;
  logic          backemf_transparent_bit_q;
  logic          backemf_gain_bit_q;
  logic          low_power_bit_q;
  logic [2:0]    active_res_q;
  logic [4:0]    applied_code_q;
  logic          step_prev_q;
  logic          zero_prev_q;
  logic [VW-1:0] bemf_sample_q;

  // ***************************************************************
  // bus decode
  // ***************************************************************
  wire        bus_req    = avs_read | avs_write;
  wire        bus_done   = bus_req & ~avs_waitrequest;
  wire        wr_done    = bus_done & avs_write;
  wire        hit_ctrl0  = avs_address == mstr_pkg::OFS_CTRL0;
  wire        hit_ctrl1  = avs_address == mstr_pkg::OFS_CTRL1;
  wire        hit_ctrl2  = avs_address == mstr_pkg::OFS_CTRL2;
  wire        hit_status = avs_address == mstr_pkg::OFS_STATUS;
  wire        wr_c0_lo   = wr_done & hit_ctrl0 & avs_byteenable[0];
  wire        wr_c0_hi   = wr_done & hit_ctrl0 & avs_byteenable[1];
  wire        wr_c1      = wr_done & hit_ctrl1 & avs_byteenable[0];
  wire        wr_c2      = wr_done & hit_ctrl2 & avs_byteenable[0];

  // read mux; unmapped words read as zero
  wire [31:0] rd_ctrl0  = {19'h0, peak_amplitude_code_q, 5'h0,
                           step_resolution_q};
  wire [31:0] rd_ctrl1  = {30'h0, step_edge_select_q,
                           rotation_sense_bit_q};
  wire [31:0] rd_ctrl2  = {29'h0, low_power_bit_q, backemf_gain_bit_q,
                           backemf_transparent_bit_q};
  wire [31:0] rd_status = {18'h0, current_range, 1'b0, active_res_q,
                           1'b0, microstep_index};
  wire [31:0] rd_data   = hit_ctrl0  ? rd_ctrl0  :
                          hit_ctrl1  ? rd_ctrl1  :
                          hit_ctrl2  ? rd_ctrl2  :
                          hit_status ? rd_status : 32'h0000_0000;

  // ***************************************************************
  // step qualification and position update
  // ***************************************************************
  wire       step_rise = step_pulse_input & ~step_prev_q;
  wire       step_fall = ~step_pulse_input & step_prev_q;
  wire       step_edge = step_edge_select_q ? step_fall : step_rise;
  wire       step_trig = step_edge & ~low_power_bit_q;
  wire       dir_up    = rotation_sense_pin ^ rotation_sense_bit_q;
  wire [6:0] new_step  = step_size(step_resolution_q);
  wire [6:0] old_step  = step_size(active_res_q);
  wire [6:0] snapped   = 7'(microstep_index + (new_step >> 1))
                         & ~7'(new_step - 7'h01);
  // coarser keeps any offset, finer snaps to its own grid
  wire [6:0] step_base = (new_step < old_step) ? snapped
                                               : microstep_index;
  wire [6:0] next_idx  = dir_up ? 7'(step_base + new_step)
                                : 7'(step_base - new_step);

  // position and resolution switch-over at the trigger
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      microstep_index <= mstr_pkg::RST_INDEX;
      active_res_q    <= mstr_pkg::RST_RES;
      coil_x_ref      <= 11'sh000;
      coil_y_ref      <= 11'sh3E8;
    end else if (step_trig) begin
      microstep_index <= next_idx;
      active_res_q    <= step_resolution_q;
      coil_x_ref      <= coil_val(next_idx, 1'b0);
      coil_y_ref      <= coil_val(next_idx, 1'b1);
    end
  end

  // edge memory keeps tracking in low power so wake-up sees no false edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_prev_q <= 1'b0;
    end else begin
      step_prev_q <= step_pulse_input;
    end
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_resolution_q     <= mstr_pkg::RST_RES;
      peak_amplitude_code_q <= mstr_pkg::RST_PEAK;
    end else begin
      if (wr_c0_lo) begin
        step_resolution_q <= avs_writedata[mstr_pkg::RES_LSB +: 3];
      end
      if (wr_c0_hi) begin
        peak_amplitude_code_q <= avs_writedata[mstr_pkg::PEAK_LSB +: 5];
      end
    end
  end

  // direction, edge, back-emf mode and low power bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rotation_sense_bit_q      <= 1'b0;
      step_edge_select_q        <= 1'b0;
      backemf_transparent_bit_q <= 1'b0;
      backemf_gain_bit_q        <= 1'b0;
      low_power_bit_q           <= 1'b0;
    end else begin
      if (wr_c1) begin
        rotation_sense_bit_q <= avs_writedata[mstr_pkg::ROT_BIT];
        step_edge_select_q   <= avs_writedata[mstr_pkg::EDGE_BIT];
      end
      if (wr_c2) begin
        backemf_transparent_bit_q <= avs_writedata[mstr_pkg::TRANS_BIT];
        backemf_gain_bit_q        <= avs_writedata[mstr_pkg::GAIN_BIT];
        low_power_bit_q           <= avs_writedata[mstr_pkg::LOWP_BIT];
      end
    end
  end

  // one wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_data;
      end
    end
  end

  // ***************************************************************
  // peak current, applied per pwm period
  // ***************************************************************
  wire [1:0] range_d = (applied_code_q >= mstr_pkg::RANGE3_MIN) ? 2'h3 :
                       (applied_code_q >= mstr_pkg::RANGE2_MIN) ? 2'h2 :
                       (applied_code_q >= mstr_pkg::RANGE1_MIN) ? 2'h1 :
                                                                  2'h0;

  // mid-period changes would upset the running regulator, so wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      applied_code_q  <= mstr_pkg::RST_PEAK;
      peak_current_ma <= mstr_pkg::PEAK_MA[0];
    end else if (pwm_period_start) begin
      applied_code_q  <= peak_amplitude_code_q;
      peak_current_ma <= mstr_pkg::PEAK_MA[peak_amplitude_code_q];
    end
  end

  // low-side impedance range follows the applied code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      current_range <= 2'h0;
    end else begin
      current_range <= range_d;
    end
  end

  // ***************************************************************
  // back-emf sample and hold
  // ***************************************************************
  wire          coil_zero = coil_zero_x | coil_zero_y;
  wire          zero_end  = zero_prev_q & ~coil_zero;
  wire [VW-1:0] live_scl  = backemf_gain_bit_q ? (coil_voltage >> 2)
                                               : (coil_voltage >> 1);
  wire [VW-1:0] held_scl  = backemf_gain_bit_q ? (bemf_sample_q >> 2)
                                               : (bemf_sample_q >> 1);

  // track samples during the zero window, publish at its end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_prev_q        <= 1'b0;
      bemf_sample_q      <= '0;
      backemf_output_pin <= '0;
    end else begin
      zero_prev_q <= coil_zero;
      if (coil_zero & pwm_sample_strobe) begin
        bemf_sample_q <= coil_voltage;
      end
      if (backemf_transparent_bit_q) begin
        backemf_output_pin <= live_scl;
      end else if (zero_end) begin
        backemf_output_pin <= held_scl;
      end
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_step_dir_up: assert property (
    @(posedge clk) disable iff (rst)
    (step_trig && step_resolution_q == active_res_q &&
     (rotation_sense_pin ^ rotation_sense_bit_q))
    |=> microstep_index == 7'($past(microstep_index) + $past(new_step)))
    else $error("step up moved by wrong amount");

  chk_step_dir_down: assert property (
    @(posedge clk) disable iff (rst)
    (step_trig && step_resolution_q == active_res_q && !dir_up)
    |=> microstep_index == 7'($past(microstep_index) - $past(new_step)))
    else $error("step down moved by wrong amount");

  chk_rise_edge_trig: assert property (
    @(posedge clk) disable iff (rst)
    (step_pulse_input && !step_prev_q && !step_edge_select_q &&
     !low_power_bit_q) |=> microstep_index != $past(microstep_index))
    else $error("rising step edge did not move position");

  chk_low_power_hold: assert property (
    @(posedge clk) disable iff (rst)
    low_power_bit_q |=> $stable(microstep_index) && $stable(active_res_q))
    else $error("position moved in low power");

  chk_res_deferred: assert property (
    @(posedge clk) disable iff (rst)
    !step_trig |=> $stable(active_res_q))
    else $error("resolution changed without a step trigger");

  chk_coil_map_pts: assert property (
    @(posedge clk) disable iff (rst)
    (microstep_index == 7'h70) |->
    (coil_x_ref == -11'sd651 && coil_y_ref == 11'sd651))
    else $error("coil values wrong at position 112");

  chk_finer_snap: assert property (
    @(posedge clk) disable iff (rst)
    (step_trig && new_step < old_step)
    |=> (microstep_index & 7'($past(new_step) - 7'h01)) == 7'h00)
    else $error("finer resolution left position off grid");

  chk_peak_at_pwm: assert property (
    @(posedge clk) disable iff (rst)
    !pwm_period_start |=> $stable(peak_current_ma) ##1
    (current_range == $past(range_d)))
    else $error("peak current changed outside pwm period start");

  chk_range_top: assert property (
    @(posedge clk) disable iff (rst)
    (applied_code_q >= 5'h17) |=> current_range == 2'h3)
    else $error("top current range not selected");

  chk_hold_sample: assert property (
    @(posedge clk) disable iff (rst)
    (!backemf_transparent_bit_q && !zero_end)
    |=> $stable(backemf_output_pin))
    else $error("held back-emf output changed outside zero end");

endmodule : mstr_translator

// ### test/mstr_step_host.sv
`timescale 1ns/1ps

// ***************************************************************
// microcontroller side of the step and direction pins
// ***************************************************************
module mstr_step_host (
  // clock
  input  wire logic clk,
  // motion pins
  output logic      step_pulse_input,
  output logic      rotation_sense_pin
);

  // pins idle low until the bench asks for motion
  initial begin
    step_pulse_input   = 1'b0;
    rotation_sense_pin = 1'b0;
  end

  // two cycles high and low, so a slow sampler never misses an edge
  task pulse();
    @(posedge clk);
    step_pulse_input <= 1'b1;
    repeat (2) @(posedge clk);
    step_pulse_input <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // direction is only moved between pulses, never across a step edge
  task sense(input logic b);
    @(posedge clk);
    rotation_sense_pin <= b;
  endtask : sense

endmodule : mstr_step_host

// ### test/mstr_translator_tb.sv
`timescale 1ns/1ps

module mstr_translator_tb;

  // ***************************************************************
  // signals
  // ***************************************************************
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic        [3:0]  avs_address = 4'h0;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic        [31:0] avs_writedata = 32'h0;
  logic        [31:0] avs_readdata;
  logic               avs_waitrequest;
  logic               step_pulse_input;
  logic               rotation_sense_pin;
  logic               pwm_period_start = 1'b0;
  logic               pwm_sample_strobe = 1'b0;
  logic               coil_zero_x = 1'b0;
  logic               coil_zero_y = 1'b0;
  logic        [9:0]  coil_voltage = 10'h000;
  logic signed [10:0] coil_x_ref;
  logic signed [10:0] coil_y_ref;
  logic        [9:0]  peak_current_ma;
  logic        [1:0]  current_range;
  logic        [9:0]  backemf_output_pin;
  logic        [6:0]  microstep_index;
  logic        [31:0] rd;
  logic               rot_bit = 1'b0;
  logic               lowp = 1'b0;
  logic        [9:0]  v1;
  int                 miscompares = 0;
  int                 compares = 0;
  int                 cycles = 0;
  int                 m_idx = 0;
  int                 m_res = 0;
  int                 m_pend = 0;
  int                 m_peak = 0;
  int                 m_appl = 0;
  int                 tbl [9] = '{0, 1, 2, 3, 4, 3, 2, 1, 0};

  mstr_translator i_mstr_translator (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .step_pulse_input(step_pulse_input),
    .rotation_sense_pin(rotation_sense_pin),
    .pwm_period_start(pwm_period_start),
    .pwm_sample_strobe(pwm_sample_strobe), .coil_zero_x(coil_zero_x),
    .coil_zero_y(coil_zero_y), .coil_voltage(coil_voltage),
    .coil_x_ref(coil_x_ref), .coil_y_ref(coil_y_ref),
    .peak_current_ma(peak_current_ma), .current_range(current_range),
    .backemf_output_pin(backemf_output_pin),
    .microstep_index(microstep_index));

  mstr_step_host i_host (
    .clk(clk), .step_pulse_input(step_pulse_input),
    .rotation_sense_pin(rotation_sense_pin));

  // ***************************************************************
  // clock, watchdog, reporting
  // ***************************************************************
  always #25 clk = ~clk;

  // whole run needs a few hundred cycles; a hang ends here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  task results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  // one avalon transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input int d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= 32'(d);
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  // ***************************************************************
  // reference model
  // ***************************************************************
  function automatic int stp(int code);
    return (code > 3) ? 16 : (1 << code);
  endfunction : stp

  // coil y runs a quarter turn ahead of coil x
  function automatic logic [10:0] coil(int i, bit y);
    int r;
    int q;
    int v;
    i = y ? (i + 32) % 128 : i;
    r = i % 32;
    q = i / 32;
    v = (q % 2) ? mstr_pkg::QUAD_LUT[32 - r] : mstr_pkg::QUAD_LUT[r];
    v = (q >= 2) ? -v : v;
    return v[10:0];
  endfunction : coil

  // pending resolution lands on the trigger; finer first rounds
  task trig(input bit up);
    int s;
    s = stp(m_pend);
    if (s < stp(m_res)) m_idx = ((m_idx + s / 2) / s) * s;
    m_res = m_pend;
    m_idx = (m_idx + (up ? s : 128 - s)) % 128;
  endtask : trig

  task stepn(input int n);
    repeat (n) begin
      i_host.sense(1'($urandom % 2));
      i_host.pulse();
      if (!lowp) trig(rotation_sense_pin ^ rot_bit);
      check(microstep_index, m_idx);
      check(coil_x_ref[10:0], coil(m_idx, 0));
      check(coil_y_ref[10:0], coil(m_idx, 1));
    end
  endtask : stepn

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    void'($urandom(42));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(microstep_index, 0);
    check(coil_y_ref[10:0], 11'h3E8);
    check(peak_current_ma, 10'h00F);
    bus(1'b0, 4'h2, 0);
    check(rd, 0);
    // resolutions fine to coarse and back, then random, both edges
    for (int k = 0; k < 14; k++) begin
      rot_bit = 1'($urandom % 2);
      bus(1'b1, mstr_pkg::OFS_CTRL1, (($urandom % 2) << 1) | rot_bit);
      m_pend = (k < 9) ? tbl[k] : int'($urandom % 8);
      bus(1'b1, mstr_pkg::OFS_CTRL0, m_pend);
      bus(1'b0, mstr_pkg::OFS_STATUS, 0);
      check(rd[10:8], m_res);
      stepn(3);
      bus(1'b0, mstr_pkg::OFS_STATUS, 0);
      check(rd[6:0], m_idx);
      check(rd[10:8], m_res);
    end
    // low power: pulses and direction ignored, state kept
    bus(1'b1, mstr_pkg::OFS_CTRL2, 4);
    lowp = 1'b1;
    stepn(3);
    bus(1'b0, mstr_pkg::OFS_CTRL0, 0);
    check(rd[2:0], m_pend);
    bus(1'b1, mstr_pkg::OFS_CTRL2, 0);
    lowp = 1'b0;
    stepn(2);
    // peak code waits for the pwm period, then sets level and range
    for (int k = 0; k < 12; k++) begin
      m_peak = (k < 8) ? tbl[k] * 8 - (k % 2) : int'($urandom % 32);
      m_peak = (m_peak > 31) ? 31 : m_peak;
      bus(1'b1, mstr_pkg::OFS_CTRL0, m_peak * 256 + m_pend);
      check(peak_current_ma, mstr_pkg::PEAK_MA[m_appl]);
      repeat (2) @(posedge clk);
      check(peak_current_ma, mstr_pkg::PEAK_MA[m_appl]);
      pwm_period_start <= 1'b1;
      @(posedge clk);
      pwm_period_start <= 1'b0;
      repeat (2) @(posedge clk);
      check(peak_current_ma, mstr_pkg::PEAK_MA[m_peak]);
      check(current_range, (m_peak > 22) + (m_peak > 15) + (m_peak > 8));
      m_appl = m_peak;
    end
    // back-emf: live path, then held sample per coil
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, mstr_pkg::OFS_CTRL2, g * 2 + 1);
      coil_voltage <= 10'($urandom);
      repeat (3) @(posedge clk);
      check(backemf_output_pin, coil_voltage >> (g + 1));
      bus(1'b1, mstr_pkg::OFS_CTRL2, g * 2);
      v1 = 10'($urandom);
      coil_voltage <= v1;
      coil_zero_x  <= (g == 0);
      coil_zero_y  <= (g == 1);
      @(posedge clk);
      pwm_sample_strobe <= 1'b1;
      @(posedge clk);
      pwm_sample_strobe <= 1'b0;
      coil_voltage      <= ~v1;
      @(posedge clk);
      coil_zero_x <= 1'b0;
      coil_zero_y <= 1'b0;
      repeat (3) @(posedge clk);
      check(backemf_output_pin, v1 >> (g + 1));
      coil_voltage <= 10'($urandom);
      repeat (3) @(posedge clk);
      check(backemf_output_pin, v1 >> (g + 1));
    end
    results();
  end

endmodule : mstr_translator_tb
